// File: hw/ddr_cmd_if.sv
`timescale 1ns/1ps
interface ddr_cmd_if;
   logic       cke;
   logic       cs_n;
   logic       ras_n;
   logic       cas_n;
   logic       we_n;
   logic [2:0] ba;
   logic [15:0] addr;
   logic       odt;

   modport controller (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
   modport memory     (input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, odt);
endinterface

// File: hw/mode_reg_controller.sv
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module mode_reg_controller
   import mr_pkg::*;
(
   // clock and reset
   input  logic        aclk,
   input  logic        aresetn,
   input  logic        clk_en,
   // axi4-lite write
   input  logic [3:0]  awaddr,
   input  logic        awvalid,
   output logic        awready,
   input  logic [31:0] wdata,
   input  logic [3:0]  wstrb,
   input  logic        wvalid,
   output logic        wready,
   output logic [1:0]  bresp,
   output logic        bvalid,
   input  logic        bready,
   // axi4-lite read
   input  logic [3:0]  araddr,
   input  logic        arvalid,
   output logic        arready,
   output logic [31:0] rdata,
   output logic [1:0]  rresp,
   output logic        rvalid,
   input  logic        rready,
   // command pins
   ddr_cmd_if.controller mem
);

   typedef struct packed {
      logic        aw_got;
      logic        w_got;
      logic [3:0]  aw_q;
      logic [31:0] w_q;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [16:0] cmd;
      logic [1:0]  ctrl;
      logic        refused;
      logic [15:0] cfg1;
      logic [15:0] cfg2;
      logic [9:0]  lock_cnt;
      logic        in_sr;
      logic        cke;
      logic [3:0]  pins;
      logic [2:0]  ba;
      logic [15:0] addr;
      logic        odt;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;

   always_comb begin
      logic        launch;
      logic        clr;
      logic        refuse;
      logic [15:0] val;
      launch = 1'b0;
      clr = 1'b0;
      refuse = 1'b0;
      val = 16'h0000;
      next_s = s;
      next_s.pins = CMD_DESELECT;
      if (awvalid && s.awready) begin
         next_s.aw_got = 1'b1;
         next_s.aw_q = awaddr;
      end
      if (wvalid && s.wready) begin
         next_s.w_got = 1'b1;
         next_s.w_q = wdata;
      end
      // response only after both halves arrived
      if (s.aw_got && s.w_got && !s.bvalid) begin
         next_s.aw_got = 1'b0;
         next_s.w_got = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = RESP_OKAY;
         case (s.aw_q)
            REG_MRS_CMD: begin
               next_s.cmd = s.w_q[16:0];
               launch = 1'b1;
            end
            REG_CTRL: next_s.ctrl = s.w_q[1:0];
            REG_STATUS: clr = s.w_q[ST_REFUSED];
            default: next_s.bresp = RESP_DECERR;
         endcase
      end
      if (s.bvalid && bready) begin
         next_s.bvalid = 1'b0;
      end
      if (s.lock_cnt != 10'h000) begin
         next_s.lock_cnt = s.lock_cnt - 10'h001;
      end
      if (launch) begin
         val = s.w_q[15:0];
         if (!s.w_q[CMD_TARGET_BIT]) begin
            val = val & M1_KEEP;
            if (val[M1_DLL_OFF]) begin
               val[M1_NOM_HI] = 1'b0;
               val[M1_NOM_MID] = 1'b0;
               val[M1_NOM_LO] = 1'b0;
            end
            refuse = nom_code(val) > NOM_WRITE_MAX
                     && !(val[M1_WR_LEVEL] && val[M1_OUT_OFF]);
         end else begin
            val = val & M2_KEEP;
            if (s.cfg1[M1_DLL_OFF]) begin
               val[M2_WTERM_LO +: 2] = 2'h0;
            end
         end
         // no set command while the device sits in self refresh
         if (s.in_sr) begin
            refuse = 1'b1;
         end
         if (!refuse) begin
            next_s.pins = CMD_MRS;
            next_s.addr = val;
            if (!s.w_q[CMD_TARGET_BIT]) begin
               next_s.ba = BANK_MODE_ONE;
               next_s.cfg1 = val;
               if (s.cfg1[M1_DLL_OFF] && !val[M1_DLL_OFF]) begin
                  next_s.lock_cnt = LOOP_LOCK_WAIT;
               end
            end else begin
               next_s.ba = BANK_MODE_TWO;
               next_s.cfg2 = val;
            end
         end
      end
      // self refresh held off until the loop has locked
      if (!launch && s.ctrl[CTRL_SREF] && !s.in_sr && s.lock_cnt == 10'h000) begin
         next_s.pins = CMD_REF;
         next_s.cke = 1'b0;
         next_s.in_sr = 1'b1;
      end else if (!s.ctrl[CTRL_SREF] && s.in_sr) begin
         next_s.cke = 1'b1;
         next_s.in_sr = 1'b0;
      end
      next_s.odt = s.ctrl[CTRL_ODT] && !next_s.cfg1[M1_DLL_OFF]
                   && next_s.lock_cnt == 10'h000 && !next_s.in_sr;
      next_s.refused = (s.refused && !clr) || refuse;
      if (arvalid && s.arready) begin
         next_s.rvalid = 1'b1;
         next_s.rresp = RESP_OKAY;
         next_s.rdata = 32'h0000_0000;
         case (araddr)
            REG_MRS_CMD: next_s.rdata = {15'h0000, s.cmd};
            REG_CTRL: next_s.rdata = {30'h0000_0000, s.ctrl};
            REG_STATUS: begin
               next_s.rdata[ST_BUSY] = s.lock_cnt != 10'h000;
               next_s.rdata[ST_REFUSED] = s.refused;
               next_s.rdata[ST_SREF] = s.in_sr;
               next_s.rdata[ST_DLL_OFF] = s.cfg1[M1_DLL_OFF];
            end
            default: next_s.rresp = RESP_DECERR;
         endcase
      end
      if (s.rvalid && rready) begin
         next_s.rvalid = 1'b0;
      end
      next_s.awready = !next_s.aw_got && !next_s.bvalid;
      next_s.wready = !next_s.w_got && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.cfg1 <= MR_RESET;
         s.cfg2 <= MR_RESET;
         s.cke <= PIN_HIGH;
         s.pins <= CMD_DESELECT;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign awready   = s.awready;
   assign wready    = s.wready;
   assign bvalid    = s.bvalid;
   assign bresp     = s.bresp;
   assign arready   = s.arready;
   assign rvalid    = s.rvalid;
   assign rdata     = s.rdata;
   assign rresp     = s.rresp;
   assign mem.cke   = s.cke;
   assign mem.cs_n  = s.pins[3];
   assign mem.ras_n = s.pins[2];
   assign mem.cas_n = s.pins[1];
   assign mem.we_n  = s.pins[0];
   assign mem.ba    = s.ba;
   assign mem.addr  = s.addr;
   assign mem.odt   = s.odt;

endmodule

// File: hw/mode_reg_device.sv
`timescale 1ns/1ps
module mode_reg_device
   import mr_pkg::*;
(
   // clock and reset
   input  logic        aclk,
   input  logic        aresetn,
   input  logic        clk_en,
   // command pins
   ddr_cmd_if.memory   mem,
   // core side
   input  logic [4:0]  column_read_delay,
   input  logic        write_burst,
   input  logic        read_drive,
   // mode state
   output logic [15:0] mode_config_one,
   output logic [15:0] mode_config_two,
   output logic [1:0]  mode_loaded,
   output logic        self_refresh,
   output logic        dll_on,
   output logic        dll_locked,
   // decoded settings
   output logic [1:0]  drive_impedance,
   output logic [2:0]  term_applied,
   output logic        term_from_write,
   output logic [5:0]  read_latency_total,
   output logic [5:0]  write_latency_total,
   output logic        outputs_disconnected,
   output logic        dq_drive_en,
   output logic [2:0]  partial_lost_segments,
   output logic        refresh_rate_2x,
   output logic        write_needs_dll,
   output logic        write_leveling,
   // sticky misuse flags
   output logic        reserved_seen,
   output logic        early_read_seen,
   output logic        lock_cke_low_seen,
   output logic        odt_dll_off_seen
);

   typedef struct packed {
      logic [15:0] cfg1;
      logic [15:0] cfg2;
      logic [1:0]  loaded;
      logic        cke_prev;
      logic        sref;
      logic        dll_on;
      logic [9:0]  lock_cnt;
      logic        locked;
      logic [1:0]  imp;
      logic [2:0]  term;
      logic        term_wr;
      logic [5:0]  rlt;
      logic [5:0]  wlt;
      logic        out_off;
      logic        dq_en;
      logic [2:0]  lost;
      logic        rate_2x;
      logic        wr_dll;
      logic        wr_level;
      logic        rsv_seen;
      logic        early_rd;
      logic        cke_low;
      logic        odt_off;
   } dev_state_t;

   dev_state_t s;
   dev_state_t next_s;

   logic [3:0] cmd;
   logic [1:0] wterm;
   logic [2:0] nom;

   assign cmd = {mem.cs_n, mem.ras_n, mem.cas_n, mem.we_n};

   always_comb begin
      next_s = s;
      next_s.loaded = 2'h0;
      // inputs come from the controller on aclk, so no synchroniser here
      if (cmd == CMD_MRS && mem.ba == BANK_MODE_ONE) begin
         next_s.cfg1 = mem.addr;
         next_s.loaded = 2'h1;
         if ((mem.addr & ~M1_KEEP) != 16'h0000) begin
            next_s.rsv_seen = 1'b1;
         end
         // loop enabled again: restart the lock count
         if (s.cfg1[M1_DLL_OFF] && !mem.addr[M1_DLL_OFF]) begin
            next_s.lock_cnt = LOOP_LOCK_WAIT;
            next_s.locked = 1'b0;
         end
      end else if (cmd == CMD_MRS && mem.ba == BANK_MODE_TWO) begin
         next_s.cfg2 = mem.addr;
         next_s.loaded = 2'h2;
         if ((mem.addr & ~M2_KEEP) != 16'h0000) begin
            next_s.rsv_seen = 1'b1;
         end
      end
      // self refresh enters on refresh with clock enable falling
      if (s.cke_prev && !mem.cke && cmd == CMD_REF) begin
         next_s.sref = 1'b1;
      end else if (s.sref && mem.cke) begin
         next_s.sref = 1'b0;
      end
      next_s.cke_prev = mem.cke;
      next_s.dll_on = !next_s.cfg1[M1_DLL_OFF] && !next_s.sref;
      // lock wait only meaningful while the loop runs
      if (s.lock_cnt != 10'h000 && next_s.lock_cnt == s.lock_cnt) begin
         next_s.lock_cnt = s.lock_cnt - 10'h001;
         if (s.lock_cnt == 10'h001) begin
            next_s.locked = 1'b1;
         end
         if (!mem.cke) begin
            next_s.cke_low = 1'b1;
         end
         if (cmd == CMD_READ) begin
            next_s.early_rd = 1'b1;
         end
      end
      if (next_s.cfg1[M1_DLL_OFF]) begin
         next_s.locked = 1'b0;
         next_s.lock_cnt = 10'h000;
         if (mem.odt && nom_code(next_s.cfg1) != 3'h0) begin
            next_s.odt_off = 1'b1;
         end
         if (next_s.cfg2[M2_WTERM_LO +: 2] != 2'h0) begin
            next_s.odt_off = 1'b1;
         end
      end else if (s.lock_cnt == 10'h000 && next_s.lock_cnt == 10'h000) begin
         next_s.locked = 1'b1;
      end
      next_s.imp = {next_s.cfg1[M1_IMP_HI], next_s.cfg1[M1_IMP_LO]};
      next_s.wr_level = next_s.cfg1[M1_WR_LEVEL];
      nom = nom_code(next_s.cfg1);
      wterm = next_s.cfg2[M2_WTERM_LO +: 2];
      // termination only while the pin asks for it
      next_s.term = 3'h0;
      next_s.term_wr = 1'b0;
      if (mem.odt) begin
         if (write_burst && wterm != 2'h0 && !next_s.wr_level) begin
            next_s.term = {1'b0, wterm};
            next_s.term_wr = 1'b1;
         end else begin
            next_s.term = nom;
         end
      end
      next_s.rlt = add_lat_cycles(next_s.cfg1[M1_ADD_LAT_LO +: 2], column_read_delay)
                   + {1'b0, column_read_delay};
      next_s.wlt = add_lat_cycles(next_s.cfg1[M1_ADD_LAT_LO +: 2], column_read_delay)
                   + {3'h0, next_s.cfg2[M2_WR_DELAY_LO +: 3]} + WR_DELAY_BASE;
      next_s.out_off = next_s.cfg1[M1_OUT_OFF];
      next_s.dq_en = read_drive && !next_s.cfg1[M1_OUT_OFF];
      // zero means whole array kept even in self refresh
      next_s.lost = next_s.sref ? next_s.cfg2[M2_PARTIAL_LO +: 3] : 3'h0;
      next_s.rate_2x = next_s.cfg2[M2_RATE_2X];
      next_s.wr_dll = wterm != 2'h0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.cfg1 <= MR_RESET;
         s.cfg2 <= MR_RESET;
         // idle level of the pin, so no false fall right after reset
         s.cke_prev <= PIN_HIGH;
         s.dll_on <= PIN_HIGH;
         s.locked <= PIN_HIGH;
      end else if (clk_en) begin
         s <= next_s;
      end
   end

   assign mode_config_one      = s.cfg1;
   assign mode_config_two      = s.cfg2;
   assign mode_loaded          = s.loaded;
   assign self_refresh         = s.sref;
   assign dll_on               = s.dll_on;
   assign dll_locked           = s.locked;
   assign drive_impedance      = s.imp;
   assign term_applied         = s.term;
   assign term_from_write      = s.term_wr;
   assign read_latency_total   = s.rlt;
   assign write_latency_total  = s.wlt;
   assign outputs_disconnected = s.out_off;
   assign dq_drive_en          = s.dq_en;
   assign partial_lost_segments = s.lost;
   assign refresh_rate_2x      = s.rate_2x;
   assign write_needs_dll      = s.wr_dll;
   assign write_leveling       = s.wr_level;
   assign reserved_seen        = s.rsv_seen;
   assign early_read_seen      = s.early_rd;
   assign lock_cke_low_seen    = s.cke_low;
   assign odt_dll_off_seen     = s.odt_off;

endmodule

// File: hw/mr_pkg.sv
package mr_pkg;
   // bank codes that pick a mode register during a mode register set
   localparam logic [2:0]  BANK_MODE_ONE   = 3'h1;
   localparam logic [2:0]  BANK_MODE_TWO   = 3'h2;
   // pin command codes {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0]  CMD_MRS         = 4'h0;
   localparam logic [3:0]  CMD_REF         = 4'h1;
   localparam logic [3:0]  CMD_READ        = 4'h5;
   localparam logic [3:0]  CMD_DESELECT    = 4'hf;
   // mode_config_one field positions
   localparam int          M1_DLL_OFF      = 0;
   localparam int          M1_IMP_LO       = 1;
   localparam int          M1_NOM_LO       = 2;
   localparam int          M1_ADD_LAT_LO   = 3;
   localparam int          M1_IMP_HI       = 5;
   localparam int          M1_NOM_MID      = 6;
   localparam int          M1_WR_LEVEL     = 7;
   localparam int          M1_NOM_HI       = 9;
   localparam int          M1_OUT_OFF      = 12;
   // mode_config_two field positions
   localparam int          M2_PARTIAL_LO   = 0;
   localparam int          M2_WR_DELAY_LO  = 3;
   localparam int          M2_RATE_2X      = 7;
   localparam int          M2_WTERM_LO     = 9;
   // bits that are not reserved
   localparam logic [15:0] M1_KEEP         = 16'h1aff;
   localparam logic [15:0] M2_KEEP         = 16'h06ff;
   localparam logic [15:0] MR_RESET        = 16'h0000;
   // latency encodings
   localparam logic [1:0]  ADD_LAT_MINUS1  = 2'h1;
   localparam logic [1:0]  ADD_LAT_MINUS2  = 2'h2;
   localparam logic [5:0]  WR_DELAY_BASE   = 6'h05;
   // highest nominal termination code that is a divide-by-2, 4 or 6 value
   localparam logic [2:0]  NOM_WRITE_MAX   = 3'h3;
   // loop_lock_wait in clock cycles
   localparam logic [9:0]  LOOP_LOCK_WAIT  = 10'h200;
   localparam logic        PIN_HIGH        = 1'h1;
   // controller register map
   localparam logic [3:0]  REG_MRS_CMD     = 4'h0;
   localparam logic [3:0]  REG_CTRL        = 4'h4;
   localparam logic [3:0]  REG_STATUS      = 4'h8;
   localparam int          CMD_TARGET_BIT  = 16;
   localparam int          CTRL_ODT        = 0;
   localparam int          CTRL_SREF       = 1;
   localparam int          ST_BUSY         = 0;
   localparam int          ST_REFUSED      = 1;
   localparam int          ST_SREF         = 2;
   localparam int          ST_DLL_OFF      = 3;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_DECERR     = 2'h3;

   function automatic logic [2:0] nom_code(input logic [15:0] m1);
      return {m1[M1_NOM_HI], m1[M1_NOM_MID], m1[M1_NOM_LO]};
   endfunction

   function automatic logic [5:0] add_lat_cycles(input logic [1:0] code,
                                                 input logic [4:0] rd_delay);
      logic [5:0] r;
      r = 6'h00;
      if (code == ADD_LAT_MINUS1) begin
         r = {1'b0, rd_delay} - 6'h01;
      end else if (code == ADD_LAT_MINUS2) begin
         r = {1'b0, rd_delay} - 6'h02;
      end
      return r;
   endfunction
endpackage

// File: test/mode_link_checker.sv
`timescale 1ns/1ps
module mode_link_checker
   import mr_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // command pins
   input  wire logic        cke,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  ba,
   input  wire logic [15:0] addr,
   input  wire logic        odt
);
   logic       mrs;
   logic       rd;
   logic       dll_off;
   logic [9:0] lock_cnt;

   assign mrs = ({cs_n, ras_n, cas_n, we_n} == CMD_MRS);
   assign rd  = ({cs_n, ras_n, cas_n, we_n} == CMD_READ);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dll_off  <= 1'b0;
         lock_cnt <= 10'h000;
      end else begin
         if (mrs && ba == BANK_MODE_ONE) begin
            dll_off <= addr[M1_DLL_OFF];
         end
         if (mrs && ba == BANK_MODE_ONE && dll_off && !addr[M1_DLL_OFF]) begin
            // two short of the wait so a late count start cannot false-fire
            lock_cnt <= LOOP_LOCK_WAIT - 10'h002;
         end else if (lock_cnt != 10'h000) begin
            lock_cnt <= lock_cnt - 10'h001;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_bank_single;
      mrs |-> (ba == BANK_MODE_ONE || ba == BANK_MODE_TWO) ##1 cs_n;
   endproperty
   a_bank_single: assert property (p_bank_single)
      else $error("set command with bad bank or longer than one cycle");
   property p_one_reserved;
      mrs && ba == BANK_MODE_ONE |-> (addr & ~M1_KEEP) == 16'h0000;
   endproperty
   a_one_reserved: assert property (p_one_reserved)
      else $error("reserved bit set for first register");
   property p_two_reserved;
      mrs && ba == BANK_MODE_TWO |-> (addr & ~M2_KEEP) == 16'h0000;
   endproperty
   a_two_reserved: assert property (p_two_reserved)
      else $error("reserved bit set for second register");
   property p_nom_legal;
      mrs && ba == BANK_MODE_ONE && !(addr[M1_WR_LEVEL] && addr[M1_OUT_OFF])
         |-> {addr[M1_NOM_HI], addr[M1_NOM_MID], addr[M1_NOM_LO]} <= NOM_WRITE_MAX;
   endproperty
   a_nom_legal: assert property (p_nom_legal)
      else $error("nominal termination code not allowed");
   property p_nom_dll_off;
      mrs && ba == BANK_MODE_ONE && addr[M1_DLL_OFF]
         |-> !addr[M1_NOM_HI] && !addr[M1_NOM_MID] && !addr[M1_NOM_LO];
   endproperty
   a_nom_dll_off: assert property (p_nom_dll_off)
      else $error("nominal termination kept with loop off");
   property p_wterm_dll_off;
      mrs && ba == BANK_MODE_TWO && dll_off |-> addr[10:9] == 2'h0;
   endproperty
   a_wterm_dll_off: assert property (p_wterm_dll_off)
      else $error("write termination kept with loop off");
   property p_lock_quiet;
      lock_cnt != 10'h000 |-> cke && !rd;
   endproperty
   a_lock_quiet: assert property (p_lock_quiet)
      else $error("read or clock enable low during lock wait");
   property p_odt_low;
      dll_off || lock_cnt != 10'h000 |-> !odt;
   endproperty
   a_odt_low: assert property (p_odt_low)
      else $error("termination pin high while loop off or locking");
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb
   import mr_pkg::*;
();
   typedef struct packed {
      logic        two;
      logic [15:0] m1;
      logic [15:0] m2;
   } note_t;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        clk_en = 1'b1;
   logic [3:0]  awaddr = 4'h0;
   logic [3:0]  araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'hf;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, mode_loaded, drive_impedance;
   logic [31:0] rdata;
   logic [4:0]  column_read_delay = 5'h08;
   logic        write_burst = 1'b0, read_drive = 1'b0;
   logic [15:0] mode_config_one, mode_config_two, e1 = 16'h0, e2 = 16'h0, v;
   logic        self_refresh, dll_on, dll_locked, term_from_write, outputs_disconnected;
   logic        dq_drive_en, refresh_rate_2x, write_needs_dll, write_leveling;
   logic        reserved_seen, early_read_seen, lock_cke_low_seen, odt_dll_off_seen;
   logic [2:0]  term_applied, partial_lost_segments;
   logic [5:0]  read_latency_total, write_latency_total;
   logic [31:0] d;
   logic [1:0]  r;
   int          checks = 0;
   int          n_mismatch = 0;
   note_t       q[$];
   note_t       nt;

   ddr_cmd_if mem ();
   mode_reg_controller mode_reg_controller_inst (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .mem(mem));
   mode_reg_device mode_reg_device_inst (
      .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .mem(mem),
      .column_read_delay(column_read_delay), .write_burst(write_burst),
      .read_drive(read_drive), .mode_config_one(mode_config_one),
      .mode_config_two(mode_config_two), .mode_loaded(mode_loaded),
      .self_refresh(self_refresh), .dll_on(dll_on), .dll_locked(dll_locked),
      .drive_impedance(drive_impedance), .term_applied(term_applied),
      .term_from_write(term_from_write), .read_latency_total(read_latency_total),
      .write_latency_total(write_latency_total),
      .outputs_disconnected(outputs_disconnected), .dq_drive_en(dq_drive_en),
      .partial_lost_segments(partial_lost_segments), .refresh_rate_2x(refresh_rate_2x),
      .write_needs_dll(write_needs_dll), .write_leveling(write_leveling),
      .reserved_seen(reserved_seen), .early_read_seen(early_read_seen),
      .lock_cke_low_seen(lock_cke_low_seen), .odt_dll_off_seen(odt_dll_off_seen));
   mode_link_checker mode_link_checker_inst (
      .aclk(aclk), .aresetn(aresetn), .cke(mem.cke), .cs_n(mem.cs_n), .ras_n(mem.ras_n),
      .cas_n(mem.cas_n), .we_n(mem.we_n), .ba(mem.ba), .addr(mem.addr), .odt(mem.odt));

   always #5 aclk = ~aclk;

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic hang();
      n_mismatch++;
      summarize();
   endtask

   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("mismatch at %0t seen %h expected %h", $time, s, x);
      end
   endtask

   task automatic axi_write(input logic [3:0] a, input logic [31:0] dv, output logic [1:0] rv);
      int n;
      @(posedge aclk);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= dv;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      if (n == 64) hang();
      rv = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] dv, output logic [1:0] rv);
      int n;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      if (n == 64) hang();
      dv = rdata;
      rv = rresp;
      rready <= 1'b0;
   endtask

   // status polls cover the whole lock wait, several cycles per read
   task automatic poll(input int b, input logic want);
      logic [31:0] sd;
      logic [1:0]  sr;
      for (int n = 0; n < 400; n++) begin
         axi_read(REG_STATUS, sd, sr);
         if (sd[b] === want) return;
      end
      hang();
   endtask

   function automatic logic [5:0] add_lat(input logic [15:0] m);
      case (m[4:3])
         ADD_LAT_MINUS1: add_lat = 6'(column_read_delay) - 6'h01;
         ADD_LAT_MINUS2: add_lat = 6'(column_read_delay) - 6'h02;
         default: add_lat = 6'h00;
      endcase
   endfunction

   task automatic mrs(input logic two, input logic [15:0] mv);
      logic [1:0] mr;
      if (two) begin
         e2 = mv & M2_KEEP;
         if (e1[M1_DLL_OFF]) e2[10:9] = 2'h0;
      end else begin
         e1 = mv & M1_KEEP;
         if (mv[M1_DLL_OFF]) {e1[9], e1[6], e1[2]} = 3'h0;
      end
      q.push_back('{two, e1, e2});
      axi_write(REG_MRS_CMD, {15'h0, two, mv}, mr);
      chk(mr, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk(drive_impedance, {e1[5], e1[1]});
      chk(read_latency_total, add_lat(e1) + 6'(column_read_delay));
      chk(write_latency_total, add_lat(e1) + WR_DELAY_BASE + 6'(e2[5:3]));
      chk({outputs_disconnected, write_leveling, refresh_rate_2x, write_needs_dll},
          {e1[12], e1[7], e2[7], e2[10:9] != 2'h0});
      chk(dq_drive_en, read_drive && !e1[12]);
   endtask

   // each load pulse is matched with the oldest expectation
   always @(posedge aclk) begin
      if (aresetn && mode_loaded !== 2'h0) begin
         if (q.size() == 0) begin
            chk(mode_loaded, 2'h0);
         end else begin
            nt = q.pop_front();
            chk(mode_loaded, nt.two ? 2'h2 : 2'h1);
            chk({mode_config_one, mode_config_two}, {nt.m1, nt.m2});
         end
      end
   end

   initial begin
      void'($urandom(32'h00f12bc1));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk({mode_config_one, mode_config_two}, {MR_RESET, MR_RESET});
      chk({dll_on, dll_locked, self_refresh}, 3'h6);
      column_read_delay <= 5'h04 + 5'($urandom_range(20));
      for (int i = 0; i < 8; i++) begin
         v = 16'($urandom);
         if (!i[0]) {v[M1_NOM_HI], v[M1_DLL_OFF]} = 2'h0;
         read_drive <= i[1];
         mrs(i[0], v);
      end
      axi_write(REG_CTRL, 32'h1, r);
      mrs(1'b0, 16'h0000);
      mrs(1'b1, 16'h0400);
      write_burst <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({term_from_write, term_applied}, 4'ha);
      axi_write(REG_MRS_CMD, 32'h0000_0204, r);
      axi_read(REG_STATUS, d, r);
      chk(d[ST_REFUSED], 1'b1);
      axi_write(REG_STATUS, 32'h2, r);
      mrs(1'b0, 16'h1284);
      chk(term_applied, 3'h5);
      write_burst <= 1'b0;
      // write termination off first, or the loop goes off with it still set
      mrs(1'b1, 16'h0000);
      mrs(1'b0, 16'h0245);
      chk({dll_on, dll_locked, term_applied}, 5'h00);
      mrs(1'b1, 16'h0600);
      mrs(1'b0, 16'h0000);
      chk(dll_locked, 1'b0);
      poll(ST_BUSY, 1'b0);
      repeat (3) @(posedge aclk);
      chk(dll_locked, 1'b1);
      mrs(1'b1, 16'h0085);
      axi_write(REG_CTRL, 32'h3, r);
      poll(ST_SREF, 1'b1);
      repeat (3) @(posedge aclk);
      chk({self_refresh, dll_on, partial_lost_segments}, {2'h2, e2[2:0]});
      axi_write(REG_CTRL, 32'h1, r);
      poll(ST_SREF, 1'b0);
      repeat (3) @(posedge aclk);
      chk({self_refresh, dll_on, partial_lost_segments}, 5'h08);
      axi_write(4'hc, 32'h0, r);
      chk(r, RESP_DECERR);
      axi_read(4'hc, d, r);
      chk({r, d[15:0]}, {RESP_DECERR, 16'h0});
      axi_read(REG_MRS_CMD, d, r);
      chk(d[16:0], 17'h10085);
      // frozen clock enable must hold dq_drive_en and both mode configs, then let it follow again
      clk_en <= 1'b0;
      read_drive <= 1'b0;
      repeat (4) @(posedge aclk);
      chk({dq_drive_en, mode_config_one, mode_config_two}, {1'b1, e1, e2});
      clk_en <= 1'b1;
      repeat (2) @(posedge aclk);
      chk(dq_drive_en, 1'b0);
      chk({reserved_seen, early_read_seen, lock_cke_low_seen, odt_dll_off_seen}, 4'h0);
      chk(q.size(), 0);
      summarize();
   end
endmodule
